// File: bench/cssp_osc_model.sv
// Oscillator side model: new clock, start-up timer and PLL lock
`timescale 1ns/1ps
module cssp_osc_model #(
  parameter int LOCK_CYC = 24
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire cssp_pkg::cssp_osc_type osc_enable,
  output logic                        new_clock_pin,
  output logic                        osc_startup_timer_done,
  output logic                        pll_lock_pin
);
  logic [1:0] ph_reg;
  logic [7:0] ost_reg;
  logic [7:0] pll_reg;
  // Two cycles per phase so the three-flop synchroniser sees every edge; still when all are off
  always @(posedge mclk) begin
    ph_reg  <= (!rst_n || osc_enable === '0) ? 2'h0 : ph_reg + 2'h1;
    ost_reg <= (!rst_n || !osc_enable.pri_on) ? 8'h0 : ost_reg + {7'h0, ost_reg < 8'h14};
    pll_reg <= (!rst_n || !osc_enable.pll_on) ? 8'h0 : pll_reg + {7'h0, pll_reg < 8'(LOCK_CYC)};
  end
  assign new_clock_pin          = ph_reg[1];
  assign osc_startup_timer_done = ost_reg == 8'h14;
  assign pll_lock_pin           = pll_reg == 8'(LOCK_CYC);
endmodule

// File: bench/tb_top.sv
// Directed testbench for the clock switch and power-save block
`timescale 1ns/1ps
module tb_top;
  logic                   mclk = 1'h0;
  logic                   rst_n = 1'h0;
  logic                   sw_cfg = 1'h1;
  logic                   mon_cfg = 1'h0;
  cssp_pkg::cssp_src_type init_src = cssp_pkg::CSSP_SRC_FRC;
  cssp_pkg::cssp_wr_type  wr = '0;
  logic                   fail_pin = 1'h0;
  logic                   ps_go = 1'h0;
  logic                   ps_op = 1'h0;
  logic                   irq = 1'h0;
  logic                   wdt_en = 1'h1;
  logic                   wdt_to = 1'h0;
  logic [15:0]            cw;
  cssp_pkg::cssp_src_type sys_sel;
  cssp_pkg::cssp_osc_type osc_en;
  logic                   cpu_en, per_en, wdt_clr, trap, busy, nck, osc_startup_timer, lock;
  logic [1:0]             psub;
  int                     n_mismatch = 0;
  int                     n_tests = 0;
  int                     cyc = 0;
  int                     n;

  initial forever #50 mclk = ~mclk;

  cssp_clock_ctrl u_dut (.mclk(mclk), .rst_n(rst_n), .switch_monitor_config_bit(sw_cfg),
    .monitor_config_bit(mon_cfg), .initial_source_config(init_src), .primary_submode_config(2'h1),
    .sw_wr(wr), .watchdog_enable(wdt_en), .watchdog_timeout(wdt_to), .osc_startup_timer_done(osc_startup_timer),
    .pll_lock_pin(lock), .new_clock_pin(nck), .osc_fail_detect(fail_pin), .power_save_instruction(ps_go),
    .power_save_operand(ps_op), .int_pending(irq), .control_word(cw), .sys_clock_select(sys_sel),
    .osc_enable(osc_en), .cpu_clock_enable(cpu_en), .periph_clock_enable(per_en), .watchdog_clear(wdt_clr),
    .clock_fail_trap(trap), .switch_busy(busy), .primary_submode(psub));

  cssp_osc_model u_osc (.mclk(mclk), .rst_n(rst_n), .osc_enable(osc_en), .new_clock_pin(nck),
    .osc_startup_timer_done(osc_startup_timer), .pll_lock_pin(lock));

  // ==========================================================
  // Tasks
  task automatic complete_run();
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic do_reset(input logic sc, input logic mc, input cssp_pkg::cssp_src_type s);
    @(posedge mclk) rst_n <= 1'h0;
    sw_cfg <= sc;
    mon_cfg <= mc;
    init_src <= s;
    tick(4);
    @(posedge mclk) rst_n <= 1'h1;
    tick(2);
  endtask
  // Key pair, then the protected write in the cycle right after the second key
  task automatic key_wr(input logic hi, input logic [7:0] d);
    @(posedge mclk) wr.key_valid <= 1'h1;
    wr.key <= hi ? cssp_pkg::CSSP_KEY_HI_1 : cssp_pkg::CSSP_KEY_LO_1;
    @(posedge mclk) wr.key <= hi ? cssp_pkg::CSSP_KEY_HI_2 : cssp_pkg::CSSP_KEY_LO_2;
    @(posedge mclk) wr.key_valid <= 1'h0;
    {wr.hi_we, wr.lo_we, wr.hi_data, wr.lo_data} <= {hi, !hi, d, d};
    @(posedge mclk) {wr.hi_we, wr.lo_we} <= 2'h0;
  endtask
  task automatic switch_to(input cssp_pkg::cssp_src_type s);
    key_wr(1'h1, {5'h0, s});
    key_wr(1'h0, 8'h01);
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ==========================================================
  // Sequence
  initial begin
    do_reset(1'h1, 1'h0, cssp_pkg::CSSP_SRC_PRI);
    chk(cw[14:12], 3'h2, "status shows strap");
    chk(psub, 2'h1, "submode echo");
    switch_to(cssp_pkg::CSSP_SRC_PRI_PLL);
    tick(5);
    chk(cw[0], 1'h0, "request held low");
    chk(sys_sel, cssp_pkg::CSSP_SRC_PRI, "switch ignored");
    do_reset(1'h0, 1'h0, cssp_pkg::CSSP_SRC_FRC);
    switch_to(cssp_pkg::CSSP_SRC_FRC);
    tick(3);
    chk(busy, 1'h0, "redundant abort");
    switch_to(cssp_pkg::CSSP_SRC_PRI_PLL);
    tick(4);
    chk({busy, cw[5], cw[3]}, 3'h4, "switch started, bits cleared");
    chk(cpu_en, 1'h1, "cpu runs on old clock");
    n = 0;
    while (busy === 1'h1 && n < 3000) begin
      tick(1);
      n++;
    end
    chk(n >= 60, 1'h1, "waited for oscillator and settle");
    chk({cw[14:12], cw[10:8], cw[0]}, 7'h36, "status copied");
    chk(sys_sel, cssp_pkg::CSSP_SRC_PRI_PLL, "system clock moved");
    chk({osc_en.frc_on, osc_en.low_power_rc_osc_on}, 2'h1, "old source off, low_power_rc_osc on");
    @(posedge mclk) fail_pin <= 1'h1;
    n = 0;
    while (trap !== 1'h1 && n < 20) begin
      tick(1);
      n++;
    end
    chk(trap, 1'h1, "fail trap");
    tick(2);
    chk(sys_sel, cssp_pkg::CSSP_SRC_FRC_PLL, "fallback via pll");
    chk(cw[3], 1'h1, "fail flag set");
    // Drop the fault first: the flag is set again while the synchronised fault level stands
    @(posedge mclk) fail_pin <= 1'h0;
    tick(5);
    @(posedge mclk) wr.fail_clear <= 1'h1;
    @(posedge mclk) wr.fail_clear <= 1'h0;
    tick(2);
    chk(cw[3], 1'h0, "fail flag cleared");
    // Leave the fallback through plain fast RC; the settled bit was set on the PLL source
    switch_to(cssp_pkg::CSSP_SRC_FRC);
    tick(2);
    chk({busy, cw[5]}, 2'h2, "switch start clears settled bit");
    tick(60);
    chk({busy, cw[14:12]}, 4'h0, "back on fast RC");
    // Operand 0 is sleep, 1 is idle
    for (int m = 0; m < 2; m++) begin
      @(posedge mclk) {ps_go, ps_op} <= {1'h1, m[0]};
      @(posedge mclk) ps_go <= 1'h0;
      #1;
      chk({cpu_en, per_en, osc_en.frc_on}, {1'h0, m[0], m[0]}, "power save entry");
      chk({wdt_clr, osc_en.low_power_rc_osc_on}, 2'h3, "watchdog cleared, low_power_rc_osc on");
      tick(3);
      chk(cpu_en, 1'h0, "still asleep");
      @(posedge mclk) {irq, wdt_to} <= {!m[0], m[0]};
      tick(2);
      chk(cpu_en, 1'h1, "wake on interrupt or time-out");
      chk(sys_sel, cssp_pkg::CSSP_SRC_FRC, "same source after wake");
      @(posedge mclk) {irq, wdt_to} <= 2'h0;
    end
    @(posedge mclk) {ps_go, ps_op, irq} <= 3'h5;
    @(posedge mclk) ps_go <= 1'h0;
    #1;
    chk(cpu_en, 1'h0, "entry completes first");
    tick(3);
    chk(cpu_en, 1'h1, "coincident interrupt wakes");
    @(posedge mclk) {irq, wdt_en} <= 2'h0;
    do_reset(1'h0, 1'h1, cssp_pkg::CSSP_SRC_FRC);
    key_wr(1'h0, 8'h80);
    switch_to(cssp_pkg::CSSP_SRC_PRI);
    tick(3);
    chk({cw[7], busy}, 2'h2, "frozen refuses request");
    chk(sys_sel, cssp_pkg::CSSP_SRC_FRC, "source locked");
    chk(osc_en.low_power_rc_osc_on, 1'h0, "low_power_rc_osc off without watchdog or monitor");
    complete_run();
  end
endmodule

// File: design/cssp_clock_ctrl.sv
// Clock source switching, fail-safe monitor and sleep/idle control
// Operation
// - Switching and fail-safe monitor work only when the config bit is 0.
// - With switching off, new-source field is ignored; status shows initial config.
// - With switching off, request bit ignores writes and stays zero.
// - Request to the current source clears request and aborts.
// - A valid switch clears PLL-settled and clock-fail bits.
// - Start new oscillator, wait start-up timer for crystal, PLL lock if used.
// - Count 10 new-clock cycles before changing over.
// - On completion clear request and copy new source into status.
// - Old source stops after switch, except needed low-power RC and secondary.
// - CPU keeps running on the old clock during the whole sequence.
// - Primary submode changes only by configuration, never by switching.
// - With monitor on, low-power RC runs always except in sleep.
// - Clock failure raises a trap and falls back to fast RC.
// - Failure on a PLL source falls back to fast RC through the PLL.
// - Sleep stops the system clock source, monitor and clocked peripherals.
// - Sleep entry clears enabled watchdog; low-power RC runs if watchdog on.
// - Wake on enabled interrupt, reset or watchdog time-out; same source after sleep.
// - Idle stops CPU, clears watchdog, keeps system clock and peripherals.
// - Idle wake restores the CPU clock at once.
// - Interrupt during the power-save instruction wakes right after entry.
// - Source codes: 0 FAST_INTERNAL_RC_OSC, 1 FAST_INTERNAL_RC_OSC PLL, 2 primary, 3 primary PLL, 4..7 others.
// - Freeze bit with switching on and monitor off refuses switches.
// - Monitor sets clock-fail flag; software reads and clears it.
`timescale 1ns/1ps
module cssp_clock_ctrl (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  switch_monitor_config_bit,
  input  wire logic                  monitor_config_bit,
  input  wire cssp_pkg::cssp_src_type initial_source_config,
  input  wire logic [1:0]            primary_submode_config,
  input  wire cssp_pkg::cssp_wr_type sw_wr,
  input  wire logic                  watchdog_enable,
  input  wire logic                  watchdog_timeout,
  input  wire logic                  osc_startup_timer_done,
  input  wire logic                  pll_lock_pin,
  input  wire logic                  new_clock_pin,
  input  wire logic                  osc_fail_detect,
  input  wire logic                  power_save_instruction,
  input  wire logic                  power_save_operand,
  input  wire logic                  int_pending,
  output logic [15:0]                control_word,
  output cssp_pkg::cssp_src_type     sys_clock_select,
  output cssp_pkg::cssp_osc_type     osc_enable,
  output logic                       cpu_clock_enable,
  output logic                       periph_clock_enable,
  output logic                       watchdog_clear,
  output logic                       clock_fail_trap,
  output logic                       switch_busy,
  output logic [1:0]                 primary_submode
);
  // ==========================================================================
  // Types and state
  // ==========================================================================
  typedef struct packed {
    cssp_pkg::cssp_state_type fsm;
    cssp_pkg::cssp_src_type   cur_src;
    cssp_pkg::cssp_src_type   new_src;
    cssp_pkg::cssp_src_type   sys_src;
    cssp_pkg::cssp_src_type   old_src;
    logic                     freeze;
    logic                     sec_en;
    logic                     req;
    logic                     pll_settled;
    logic                     fail;
    logic                     new_clk_prev;
    logic [3:0]               settle_cnt;
    logic [15:0]              warm_cnt;
    logic                     started;
    logic [1:0]               submode;
    logic                     wdt_clear;
    logic                     trap;
    logic                     old_keep;
  } cssp_state_reg_type;

  cssp_state_reg_type st_reg;
  cssp_state_reg_type st_next;

  logic hi_open;
  logic lo_open;
  logic pll_lock;
  logic new_clk;
  logic fail_sync;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic uses_pll(input cssp_pkg::cssp_src_type s);
    uses_pll = (s == cssp_pkg::CSSP_SRC_FRC_PLL) || (s == cssp_pkg::CSSP_SRC_PRI_PLL);
  endfunction

  function automatic logic is_primary(input cssp_pkg::cssp_src_type s);
    is_primary = (s == cssp_pkg::CSSP_SRC_PRI) || (s == cssp_pkg::CSSP_SRC_PRI_PLL);
  endfunction

  function automatic logic is_frc(input cssp_pkg::cssp_src_type s);
    is_frc = !is_primary(s) && (s != cssp_pkg::CSSP_SRC_SEC) && (s != cssp_pkg::CSSP_SRC_LOW_POWER_RC_OSC);
  endfunction

  // ==========================================================================
  // Unlock detectors and pin synchronisers
  // ==========================================================================
  cssp_unlock u_unlock_hi (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .key_valid  (sw_wr.key_valid),
    .key        (sw_wr.key),
    .first_key  (cssp_pkg::CSSP_KEY_HI_1),
    .second_key (cssp_pkg::CSSP_KEY_HI_2),
    .open       (hi_open)
  );

  cssp_unlock u_unlock_lo (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .key_valid  (sw_wr.key_valid),
    .key        (sw_wr.key),
    .first_key  (cssp_pkg::CSSP_KEY_LO_1),
    .second_key (cssp_pkg::CSSP_KEY_LO_2),
    .open       (lo_open)
  );

  cssp_sync3 u_sync_lock (.mclk(mclk), .rst_n(rst_n), .pin(pll_lock_pin), .level(pll_lock));
  cssp_sync3 u_sync_nclk (.mclk(mclk), .rst_n(rst_n), .pin(new_clock_pin), .level(new_clk));
  cssp_sync3 u_sync_fail (.mclk(mclk), .rst_n(rst_n), .pin(osc_fail_detect), .level(fail_sync));

  // ==========================================================================
  // Control
  // ==========================================================================
  logic sw_enabled;
  logic mon_enabled;
  logic frozen;
  logic new_edge;
  logic src_ready;
  logic wake;

  assign sw_enabled  = !switch_monitor_config_bit;
  assign mon_enabled = sw_enabled && !monitor_config_bit;
  assign frozen      = st_reg.freeze && sw_enabled && !mon_enabled;
  assign new_edge    = new_clk && !st_reg.new_clk_prev;
  // Warm-up counter stands in for the start-up timer when no pin reports it
  assign src_ready   = (!is_primary(st_reg.new_src) || osc_startup_timer_done
                        || (st_reg.warm_cnt == cssp_pkg::CSSP_WARM_LAST))
                       && (!uses_pll(st_reg.new_src) || pll_lock);
  assign wake        = int_pending || watchdog_timeout;

  always_comb begin
    st_next              = st_reg;
    st_next.new_clk_prev = new_clk;
    st_next.wdt_clear    = 1'b0;
    st_next.trap         = 1'b0;
    st_next.pll_settled  = st_reg.pll_settled || (uses_pll(st_reg.sys_src) && pll_lock);
    if (!st_reg.started) begin
      // Straps are caught on the first clock after reset release
      st_next.started = 1'b1;
      st_next.submode = primary_submode_config;
      st_next.cur_src = initial_source_config;
      st_next.sys_src = initial_source_config;
      st_next.new_src = initial_source_config;
    end
    // Software writes to protected bytes
    if (sw_wr.hi_we && hi_open && sw_enabled) begin
      st_next.new_src = cssp_pkg::cssp_src_type'(sw_wr.hi_data[2:0]);
    end
    if (sw_wr.lo_we && lo_open) begin
      st_next.freeze = st_reg.freeze || sw_wr.lo_data[cssp_pkg::CSSP_FREEZE_BIT];
      st_next.sec_en = sw_wr.lo_data[cssp_pkg::CSSP_SECEN_BIT];
      if (sw_enabled && !frozen && (st_reg.fsm == cssp_pkg::CSSP_ST_RUN)) begin
        st_next.req = sw_wr.lo_data[cssp_pkg::CSSP_REQ_BIT];
      end
    end
    if (sw_wr.fail_clear) begin
      st_next.fail = 1'b0;
    end
    case (st_reg.fsm)
      cssp_pkg::CSSP_ST_RUN: begin
        if (st_reg.req) begin
          st_next.fsm = cssp_pkg::CSSP_ST_CHECK;
        end else if (power_save_instruction) begin
          st_next.wdt_clear = watchdog_enable;
          st_next.fsm = (power_save_operand == cssp_pkg::CSSP_PS_SLEEP)
                        ? cssp_pkg::CSSP_ST_SLEEP : cssp_pkg::CSSP_ST_IDLE;
        end
      end
      cssp_pkg::CSSP_ST_CHECK: begin
        if (st_reg.new_src == st_reg.cur_src) begin
          st_next.req = 1'b0;
          st_next.fsm = cssp_pkg::CSSP_ST_RUN;
        end else begin
          st_next.pll_settled = 1'b0;
          st_next.fail        = 1'b0;
          st_next.warm_cnt    = '0;
          st_next.old_src     = st_reg.sys_src;
          st_next.fsm         = cssp_pkg::CSSP_ST_WARM;
        end
      end
      cssp_pkg::CSSP_ST_WARM: begin
        if (st_reg.warm_cnt != cssp_pkg::CSSP_WARM_LAST) begin
          st_next.warm_cnt = st_reg.warm_cnt + 16'h0001;
        end
        if (src_ready) begin
          st_next.settle_cnt = '0;
          st_next.fsm        = cssp_pkg::CSSP_ST_SETTLE;
        end
      end
      cssp_pkg::CSSP_ST_SETTLE: begin
        if (new_edge) begin
          if (st_reg.settle_cnt == cssp_pkg::CSSP_SETTLE_LAST) begin
            st_next.sys_src = st_reg.new_src;
            st_next.cur_src = st_reg.new_src;
            st_next.req     = 1'b0;
            st_next.fsm     = cssp_pkg::CSSP_ST_RUN;
          end else begin
            st_next.settle_cnt = st_reg.settle_cnt + 4'h1;
          end
        end
      end
      cssp_pkg::CSSP_ST_SLEEP, cssp_pkg::CSSP_ST_IDLE: begin
        // Pending interrupt is already seen here, so wake follows entry at once
        if (wake) begin
          st_next.fsm = cssp_pkg::CSSP_ST_RUN;
        end
      end
      default: begin
        st_next.fsm = cssp_pkg::CSSP_ST_RUN;
      end
    endcase
    // Fail-safe fallback overrides any switch in progress; not active in sleep
    if (mon_enabled && fail_sync && !st_reg.fail && (st_reg.fsm != cssp_pkg::CSSP_ST_SLEEP)) begin
      st_next.fail    = 1'b1;
      st_next.trap    = 1'b1;
      st_next.sys_src = uses_pll(st_reg.sys_src) ? cssp_pkg::CSSP_SRC_FRC_PLL
                                                 : cssp_pkg::CSSP_SRC_FRC;
      st_next.cur_src = st_next.sys_src;
      st_next.req     = 1'b0;
      st_next.fsm     = (st_reg.fsm == cssp_pkg::CSSP_ST_IDLE) ? st_next.fsm
                                                              : cssp_pkg::CSSP_ST_RUN;
    end
    if (!sw_enabled) begin
      st_next.req = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '{fsm: cssp_pkg::CSSP_ST_RUN, cur_src: cssp_pkg::CSSP_SRC_FRC_DN,
                  new_src: cssp_pkg::CSSP_SRC_FRC_DN, sys_src: cssp_pkg::CSSP_SRC_FRC_DN,
                  old_src: cssp_pkg::CSSP_SRC_FRC_DN, warm_cnt: cssp_pkg::CSSP_OST_RESET,
                  default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  logic in_sleep;
  logic switching;

  assign in_sleep  = (st_reg.fsm == cssp_pkg::CSSP_ST_SLEEP);
  assign switching = (st_reg.fsm == cssp_pkg::CSSP_ST_WARM) || (st_reg.fsm == cssp_pkg::CSSP_ST_SETTLE);

  always_comb begin
    control_word = '0;
    control_word[cssp_pkg::CSSP_CUR_LSB +: 3] = st_reg.cur_src;
    control_word[cssp_pkg::CSSP_NEW_LSB +: 3] = st_reg.new_src;
    control_word[cssp_pkg::CSSP_FREEZE_BIT]   = st_reg.freeze;
    control_word[cssp_pkg::CSSP_LOCK_BIT]     = st_reg.pll_settled;
    control_word[cssp_pkg::CSSP_FAIL_BIT]     = st_reg.fail;
    control_word[cssp_pkg::CSSP_SECEN_BIT]    = st_reg.sec_en;
    control_word[cssp_pkg::CSSP_REQ_BIT]      = st_reg.req;
  end

  // System clock stays on the old source until the changeover edge
  assign sys_clock_select    = st_reg.sys_src;
  assign cpu_clock_enable    = (st_reg.fsm != cssp_pkg::CSSP_ST_SLEEP)
                               && (st_reg.fsm != cssp_pkg::CSSP_ST_IDLE);
  assign periph_clock_enable = !in_sleep;
  assign watchdog_clear      = st_reg.wdt_clear;
  assign clock_fail_trap     = st_reg.trap;
  assign switch_busy         = st_reg.req;
  assign primary_submode     = st_reg.submode;

  always_comb begin
    osc_enable         = '0;
    osc_enable.frc_on  = !in_sleep && (is_frc(st_reg.sys_src) || (switching && is_frc(st_reg.new_src)));
    osc_enable.pri_on  = !in_sleep && (is_primary(st_reg.sys_src)
                         || (switching && is_primary(st_reg.new_src)));
    osc_enable.pll_on  = !in_sleep && (uses_pll(st_reg.sys_src) || (switching && uses_pll(st_reg.new_src)));
    osc_enable.sec_on  = st_reg.sec_en || (!in_sleep && ((st_reg.sys_src == cssp_pkg::CSSP_SRC_SEC)
                         || (switching && (st_reg.new_src == cssp_pkg::CSSP_SRC_SEC))));
    osc_enable.low_power_rc_osc_on = watchdog_enable || (mon_enabled && !in_sleep)
                         || (!in_sleep && ((st_reg.sys_src == cssp_pkg::CSSP_SRC_LOW_POWER_RC_OSC)
                         || (switching && (st_reg.new_src == cssp_pkg::CSSP_SRC_LOW_POWER_RC_OSC))));
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  AST_REQ_HELD_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    switch_monitor_config_bit |=> !control_word[cssp_pkg::CSSP_REQ_BIT])
    else $error("request bit set while switching disabled");

  AST_REDUNDANT_ABORT: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_reg.fsm == cssp_pkg::CSSP_ST_CHECK) && (st_reg.new_src == st_reg.cur_src) && !fail_sync
    |=> !st_reg.req && (st_reg.fsm == cssp_pkg::CSSP_ST_RUN))
    else $error("redundant switch not aborted");

  AST_START_CLEARS: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_reg.fsm == cssp_pkg::CSSP_ST_CHECK) && (st_reg.new_src != st_reg.cur_src) && !sw_wr.fail_clear
    |=> !control_word[cssp_pkg::CSSP_LOCK_BIT] || st_reg.trap)
    else $error("settled bit not cleared at switch start");

  AST_SWITCH_DONE: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(st_reg.req) && $past(st_reg.fsm == cssp_pkg::CSSP_ST_SETTLE) && sw_enabled
    |-> st_reg.cur_src == $past(st_reg.new_src) || st_reg.trap)
    else $error("status not updated on switch completion");

  AST_OLD_CLOCK_KEPT: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_reg.fsm == cssp_pkg::CSSP_ST_WARM) ##1 (st_reg.fsm == cssp_pkg::CSSP_ST_WARM)
    |-> $stable(sys_clock_select))
    else $error("system clock moved before changeover");

  AST_FAIL_FALLBACK: assert property (@(posedge mclk) disable iff (!rst_n)
    clock_fail_trap |-> is_frc(sys_clock_select) && control_word[cssp_pkg::CSSP_FAIL_BIT])
    else $error("failure did not fall back to fast RC");

  AST_SLEEP_STOPS: assert property (@(posedge mclk) disable iff (!rst_n)
    in_sleep |-> !osc_enable.frc_on && !osc_enable.pri_on && !osc_enable.pll_on && !periph_clock_enable)
    else $error("source running in sleep");

  AST_WAKE_PROMPT: assert property (@(posedge mclk) disable iff (!rst_n)
    !cpu_clock_enable && wake |=> cpu_clock_enable)
    else $error("no wake on pending event");

  AST_SLEEP_SAME_SRC: assert property (@(posedge mclk) disable iff (!rst_n)
    in_sleep ##1 !in_sleep |-> $stable(sys_clock_select))
    else $error("source changed across sleep");

  AST_FREEZE_REFUSES: assert property (@(posedge mclk) disable iff (!rst_n)
    frozen && !st_reg.req |=> !st_reg.req)
    else $error("switch accepted while frozen");
endmodule

// File: design/cssp_pkg.sv
// Package: codes, field positions, reset values and timing counts of the clock switch block
package cssp_pkg;
  // Source codes carried by the new-source and current-source fields
  typedef enum logic [2:0] {
    CSSP_SRC_FRC      = 3'h0,
    CSSP_SRC_FRC_PLL  = 3'h1,
    CSSP_SRC_PRI      = 3'h2,
    CSSP_SRC_PRI_PLL  = 3'h3,
    CSSP_SRC_SEC      = 3'h4,
    CSSP_SRC_LOW_POWER_RC_OSC     = 3'h5,
    CSSP_SRC_FRC_D16  = 3'h6,
    CSSP_SRC_FRC_DN   = 3'h7
  } cssp_src_type;

  // Field positions inside the control word
  localparam int CSSP_CUR_LSB     = 12;
  localparam int CSSP_NEW_LSB     = 8;
  localparam int CSSP_FREEZE_BIT  = 7;
  localparam int CSSP_LOCK_BIT    = 5;
  localparam int CSSP_FAIL_BIT    = 3;
  localparam int CSSP_SECEN_BIT   = 1;
  localparam int CSSP_REQ_BIT     = 0;

  // Unlock keys written to the key port, first then second
  localparam logic [7:0] CSSP_KEY_HI_1 = 8'h46;
  localparam logic [7:0] CSSP_KEY_HI_2 = 8'h57;
  localparam logic [7:0] CSSP_KEY_LO_1 = 8'h78;
  localparam logic [7:0] CSSP_KEY_LO_2 = 8'h9A;

  // Timing
  localparam int          CSSP_CLK_HZ        = 10000000;
  localparam int          CSSP_SETTLE_CYCLES = 10;
  localparam logic [3:0]  CSSP_SETTLE_LAST   = 4'(CSSP_SETTLE_CYCLES - 1);
  localparam logic [15:0] CSSP_OST_RESET     = 16'h0000;
  localparam logic [15:0] CSSP_WARM_LAST     = 16'h03FF;

  // Operand of the power-save instruction
  localparam logic CSSP_PS_SLEEP = 1'b0;
  localparam logic CSSP_PS_IDLE  = 1'b1;

  typedef enum {
    CSSP_ST_RUN,
    CSSP_ST_CHECK,
    CSSP_ST_WARM,
    CSSP_ST_SETTLE,
    CSSP_ST_SLEEP,
    CSSP_ST_IDLE
  } cssp_state_type;

  // Software write carrier
  typedef struct packed {
    logic       key_valid;
    logic [7:0] key;
    logic       hi_we;
    logic       lo_we;
    logic [7:0] hi_data;
    logic [7:0] lo_data;
    logic       fail_clear;
  } cssp_wr_type;

  // Oscillator enable outputs
  typedef struct packed {
    logic frc_on;
    logic pri_on;
    logic sec_on;
    logic low_power_rc_osc_on;
    logic pll_on;
  } cssp_osc_type;
endpackage

// File: design/cssp_sync3.sv
// Three-stage synchroniser for a pin level; output changes when stages two and three agree
`timescale 1ns/1ps
module cssp_sync3 (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } cssp_sync_type;

  cssp_sync_type st_reg;
  cssp_sync_type st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.level = st_reg.s3;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.level;
endmodule

// File: design/cssp_unlock.sv
// Two-write unlock key detector for the protected control bytes
`timescale 1ns/1ps
module cssp_unlock (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               key_valid,
  input  wire logic [7:0]         key,
  input  wire logic [7:0]         first_key,
  input  wire logic [7:0]         second_key,
  output logic                    open
);
  typedef struct packed {
    logic armed;
    logic open;
  } cssp_unl_type;

  cssp_unl_type st_reg;
  cssp_unl_type st_next;

  // Window is one cycle only, so any stray write in between closes it
  always_comb begin
    st_next       = st_reg;
    st_next.open  = 1'b0;
    st_next.armed = key_valid && (key == first_key);
    if (key_valid && st_reg.armed && (key == second_key)) begin
      st_next.open  = 1'b1;
      st_next.armed = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign open = st_reg.open;

  AST_OPEN_AFTER_KEYS: assert property (@(posedge mclk) disable iff (!rst_n)
    open |-> $past(key_valid) && $past(key == second_key) && $past(key_valid, 2)
      && $past(key == first_key, 2)) else $error("unlock opened without key pair");
endmodule
